/* common/stopwatch_pkg.sv */
// Constants, register map and carrier types of the BCD stopwatch timer.
// Assumes a single 200 MHz bus clock and an APB master reaching the registers.
// ==========================================================================
package stopwatch_pkg;

    // ======================================================================
    // Timing
    localparam int CLK_HZ         = 200_000_000;
    localparam int TICK_HZ        = 1024;
    localparam int TICK_CYCLES    = CLK_HZ / TICK_HZ;
    localparam int DEBOUNCE_US    = 46800;
    localparam int DEBOUNCE_TICKS = (DEBOUNCE_US * TICK_HZ + 999_999) / 1_000_000;
    localparam int TICK_W         = 18;
    localparam int DEB_W          = 6;

    // ======================================================================
    // Register map: printed offsets are indexes, byte address is four times.
    localparam int              ADDR_W     = 18;
    localparam logic [15:0]     IDX_MS     = 16'hFF7A;
    localparam logic [15:0]     IDX_HUND   = 16'hFF7B;
    localparam logic [15:0]     IDX_TENTHS = 16'hFF7C;
    localparam logic [15:0]     IDX_CTRL   = 16'hFF7D;
    localparam logic [15:0]     IDX_STATUS = 16'hFF7E;

    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_CLEAR_BIT  = 1;
    localparam int CTRL_DIRECT_BIT = 2;
    localparam int CTRL_SWAP_BIT   = 3;

    localparam int ST_RENEW_BIT   = 0;
    localparam int ST_HOLD_BIT    = 1;
    localparam int ST_ONESEC_BIT  = 2;
    localparam int ST_RUNKEY_BIT  = 3;
    localparam int ST_LAPKEY_BIT  = 4;
    localparam int ST_KEY0_BIT    = 5;
    localparam int ST_KEY1_BIT    = 6;

    // ======================================================================
    // Digits and prescaler correction points
    localparam logic [3:0] DIGIT_MAX  = 4'h9;
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam int         SKIP_N     = 24;
    localparam logic [11:0] SKIP_LIST [SKIP_N] = '{
        12'h039, 12'h079, 12'h139, 12'h179, 12'h219, 12'h259, 12'h299, 12'h319,
        12'h359, 12'h399, 12'h439, 12'h479, 12'h539, 12'h579, 12'h619, 12'h659,
        12'h699, 12'h719, 12'h759, 12'h799, 12'h839, 12'h879, 12'h939, 12'h979};

    typedef struct packed {
        logic [3:0] tenths_digit;
        logic [3:0] hundredths_digit;
        logic [3:0] millisecond_digit;
    } count_type;

    localparam count_type COUNT_ZERO = '0;

endpackage

/* hw/bcd_stopwatch_timer.sv */
// BCD stopwatch timer with capture buffer, software and key control.
// Assumes keys come from pins asynchronous to pclk; registers sit on APB.
module bcd_stopwatch_timer #(
    parameter int TICK_CYCLES_P = stopwatch_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // APB slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [stopwatch_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Key ports
    input  wire logic                              key_port_zero,
    input  wire logic                              key_port_one,
    // Status outputs
    output logic                                   run_state,
    output logic                                   key_irq
);
    import stopwatch_pkg::*;

    // ======================================================================
    // Tick divider: one pclk pulse per 1,024 Hz period.
    logic [TICK_W-1:0] tick_cnt_reg;
    logic [TICK_W-1:0] tick_cnt_next;
    logic              tick_reg;
    logic              tick_next;

    always_comb
    begin
        tick_next     = (tick_cnt_reg == TICK_W'(TICK_CYCLES_P - 1));
        tick_cnt_next = tick_next ? '0 : tick_cnt_reg + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    // ======================================================================
    // Key synchronisers, sampling and release debounce.
    logic [1:0]       key_meta_reg;
    logic [1:0]       key_sync_reg;
    logic [1:0]       key_smp_reg;
    logic [1:0]       key_smp_next;
    logic [1:0]       armed_reg;
    logic [1:0]       armed_next;
    logic [DEB_W-1:0] quiet_reg [2];
    logic [DEB_W-1:0] quiet_next [2];
    logic [1:0]       press;

    always_comb
    begin
        key_smp_next = key_smp_reg;
        armed_next   = armed_reg;
        press        = 2'b00;
        for (int k = 0; k < 2; k++)
        begin
            quiet_next[k] = quiet_reg[k];
            if (tick_reg)
            begin
                key_smp_next[k] = key_sync_reg[k];
                if (key_sync_reg[k] && !key_smp_reg[k] && armed_reg[k])
                begin
                    press[k]      = 1'b1;
                    armed_next[k] = 1'b0;
                end
                if (key_sync_reg[k])
                begin
                    quiet_next[k] = '0;
                end
                else if (!armed_reg[k])
                begin
                    if (quiet_reg[k] == DEB_W'(DEBOUNCE_TICKS - 1))
                    begin
                        armed_next[k] = 1'b1;
                    end
                    else
                    begin
                        quiet_next[k] = quiet_reg[k] + 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_meta_reg <= 2'b00;
            key_sync_reg <= 2'b00;
            key_smp_reg  <= 2'b00;
            armed_reg    <= 2'b11;
            quiet_reg[0] <= '0;
            quiet_reg[1] <= '0;
        end
        else
        begin
            key_meta_reg <= {key_port_one, key_port_zero};
            key_sync_reg <= key_meta_reg;
            key_smp_reg  <= key_smp_next;
            armed_reg    <= armed_next;
            quiet_reg[0] <= quiet_next[0];
            quiet_reg[1] <= quiet_next[1];
        end
    end

    // ======================================================================
    // APB decode.
    logic [15:0] idx;
    logic        aligned;
    logic        access_first;
    logic        wr_done;
    logic        hit;

    assign idx          = paddr[ADDR_W-1:2];
    assign aligned      = (paddr[1:0] == 2'b00);
    assign access_first = psel && penable && !pready;
    assign wr_done      = psel && penable && pready && pwrite;
    assign hit          = aligned && (idx >= IDX_MS) && (idx <= IDX_STATUS);

    // ======================================================================
    // Control, run state, counters, capture buffer and flags.
    logic      run_reg, run_next, req_reg, req_next, direct_reg, direct_next;
    logic      swap_reg, swap_next, skip_reg, skip_next, hold_reg, hold_next;
    logic      renewed_reg, renewed_next, renew_flag_reg, renew_flag_next;
    logic      sec_flag_reg, sec_flag_next, runkey_flag_reg, runkey_flag_next;
    logic      lapkey_flag_reg, lapkey_flag_next, irq_next;
    count_type cnt_reg, cnt_next, cap_reg, cap_next, inc;
    logic      run_press, lap_press, clear_wr, sec_evt, in_list;
    logic      rd_ms, rd_tenths;
    logic [31:0] rdata_next;
    logic        slverr_next;

    assign run_press = direct_reg && (swap_reg ? press[1] : press[0]);
    assign lap_press = direct_reg && (swap_reg ? press[0] : press[1]);
    assign clear_wr  = wr_done && (idx == IDX_CTRL) && aligned && pwdata[CTRL_CLEAR_BIT];
    assign rd_ms     = access_first && !pwrite && aligned && (idx == IDX_MS);
    assign rd_tenths = access_first && !pwrite && aligned && (idx == IDX_TENTHS);

    always_comb
    begin
        inc     = cnt_reg;
        sec_evt = 1'b0;
        in_list = 1'b0;
        if (cnt_reg.millisecond_digit != DIGIT_MAX)
        begin
            inc.millisecond_digit = cnt_reg.millisecond_digit + 1'b1;
        end
        else
        begin
            inc.millisecond_digit = DIGIT_ZERO;
            if (cnt_reg.hundredths_digit != DIGIT_MAX)
            begin
                inc.hundredths_digit = cnt_reg.hundredths_digit + 1'b1;
            end
            else
            begin
                inc.hundredths_digit = DIGIT_ZERO;
                if (cnt_reg.tenths_digit != DIGIT_MAX)
                begin
                    inc.tenths_digit = cnt_reg.tenths_digit + 1'b1;
                end
                else
                begin
                    inc.tenths_digit = DIGIT_ZERO;
                    sec_evt          = tick_reg && run_reg && !skip_reg;
                end
            end
        end
        for (int i = 0; i < SKIP_N; i++)
        begin
            if (inc == SKIP_LIST[i])
            begin
                in_list = 1'b1;
            end
        end
    end

    always_comb
    begin
        run_next         = run_reg;
        req_next         = req_reg;
        direct_next      = direct_reg;
        swap_next        = swap_reg;
        cnt_next         = cnt_reg;
        skip_next        = skip_reg;
        cap_next         = cap_reg;
        hold_next        = hold_reg;
        renewed_next     = renewed_reg;
        renew_flag_next  = renew_flag_reg;
        sec_flag_next    = sec_flag_reg;
        runkey_flag_next = runkey_flag_reg;
        lapkey_flag_next = lapkey_flag_reg;
        irq_next         = run_press || lap_press;
        rdata_next       = '0;
        slverr_next      = 1'b0;

        // Writes, applied at the completing edge.
        if (wr_done && idx == IDX_CTRL && aligned)
        begin
            if (!direct_reg)
            begin
                req_next = pwdata[CTRL_RUN_BIT];
            end
            direct_next = pwdata[CTRL_DIRECT_BIT];
            swap_next   = pwdata[CTRL_SWAP_BIT];
        end
        if (wr_done && idx == IDX_STATUS && aligned)
        begin
            sec_flag_next    = sec_flag_reg && !pwdata[ST_ONESEC_BIT];
            runkey_flag_next = runkey_flag_reg && !pwdata[ST_RUNKEY_BIT];
            lapkey_flag_next = lapkey_flag_reg && !pwdata[ST_LAPKEY_BIT];
        end
        // Direct mode copies run_reg into the request; a run key toggle in the cycle that leaves it is undone at the next tick.
        if (direct_reg)
        begin
            req_next = run_reg;
        end

        // Run state only moves on the tick.
        if (tick_reg)
        begin
            if (direct_reg)
            begin
                if (run_press)
                begin
                    run_next = !run_reg;
                end
            end
            else
            begin
                run_next = req_reg;
            end
        end

        // Counting with pulse suppression.
        if (clear_wr)
        begin
            cnt_next  = COUNT_ZERO;
            skip_next = 1'b0;
        end
        else if (tick_reg && run_reg)
        begin
            if (skip_reg)
            begin
                skip_next = 1'b0;
            end
            else
            begin
                cnt_next  = inc;
                skip_next = in_list;
            end
        end
        if (sec_evt)
        begin
            sec_flag_next = 1'b1;
        end
        if (run_press)
        begin
            runkey_flag_next = 1'b1;
        end
        if (lap_press)
        begin
            lapkey_flag_next = 1'b1;
        end

        // Reads, data and side effects on the first access cycle.
        if (access_first && !pwrite)
        begin
            slverr_next = !hit;
            if (aligned && idx == IDX_MS)
            begin
                rdata_next[3:0] = hold_reg ? cap_reg.millisecond_digit
                                           : cnt_reg.millisecond_digit;
                if (!hold_reg)
                begin
                    cap_next  = cnt_reg;
                    hold_next = 1'b1;
                end
            end
            if (aligned && idx == IDX_HUND)
            begin
                rdata_next[3:0] = hold_reg ? cap_reg.hundredths_digit
                                           : cnt_reg.hundredths_digit;
            end
            if (aligned && idx == IDX_TENTHS)
            begin
                rdata_next[3:0] = hold_reg ? cap_reg.tenths_digit
                                           : cnt_reg.tenths_digit;
                renew_flag_next = renewed_reg;
                renewed_next    = 1'b0;
                if (!renewed_reg)
                begin
                    hold_next = 1'b0;
                end
            end
            if (aligned && idx == IDX_CTRL)
            begin
                rdata_next[CTRL_RUN_BIT]    = run_reg;
                rdata_next[CTRL_DIRECT_BIT] = direct_reg;
                rdata_next[CTRL_SWAP_BIT]   = swap_reg;
            end
            if (aligned && idx == IDX_STATUS)
            begin
                rdata_next[ST_RENEW_BIT]  = renew_flag_reg;
                rdata_next[ST_HOLD_BIT]   = hold_reg;
                rdata_next[ST_ONESEC_BIT] = sec_flag_reg;
                rdata_next[ST_RUNKEY_BIT] = runkey_flag_reg;
                rdata_next[ST_LAPKEY_BIT] = lapkey_flag_reg;
                rdata_next[ST_KEY0_BIT]   = key_sync_reg[0];
                rdata_next[ST_KEY1_BIT]   = key_sync_reg[1];
            end
        end
        else if (access_first)
        begin
            slverr_next = !hit;
        end

        // A lap wins over a read in the same cycle; the buffer takes the newer count.
        if (lap_press)
        begin
            cap_next     = cnt_reg;
            hold_next    = 1'b1;
            renewed_next = hold_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_reg         <= 1'b0;
            req_reg         <= 1'b0;
            direct_reg      <= 1'b0;
            swap_reg        <= 1'b0;
            cnt_reg         <= COUNT_ZERO;
            skip_reg        <= 1'b0;
            cap_reg         <= COUNT_ZERO;
            hold_reg        <= 1'b0;
            renewed_reg     <= 1'b0;
            renew_flag_reg  <= 1'b0;
            sec_flag_reg    <= 1'b0;
            runkey_flag_reg <= 1'b0;
            lapkey_flag_reg <= 1'b0;
            key_irq         <= 1'b0;
            prdata          <= '0;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            run_state       <= 1'b0;
        end
        else
        begin
            run_reg         <= run_next;
            req_reg         <= req_next;
            direct_reg      <= direct_next;
            swap_reg        <= swap_next;
            cnt_reg         <= cnt_next;
            skip_reg        <= skip_next;
            cap_reg         <= cap_next;
            hold_reg        <= hold_next;
            renewed_reg     <= renewed_next;
            renew_flag_reg  <= renew_flag_next;
            sec_flag_reg    <= sec_flag_next;
            runkey_flag_reg <= runkey_flag_next;
            lapkey_flag_reg <= lapkey_flag_next;
            key_irq         <= irq_next;
            prdata          <= access_first ? rdata_next : prdata;
            pready          <= access_first;
            pslverr         <= access_first ? slverr_next : 1'b0;
            run_state       <= run_next;
        end
    end

    // ======================================================================
    // Checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence free_ms_read;
        rd_ms && !hold_reg && !lap_press;
    endsequence

    sequence plain_tenths_read;
        rd_tenths && hold_reg && !renewed_reg && !lap_press;
    endsequence

    chk_digit_bcd_range: assert property (
        cnt_reg.millisecond_digit <= DIGIT_MAX && cnt_reg.hundredths_digit <= DIGIT_MAX
        && cnt_reg.tenths_digit <= DIGIT_MAX)
        else $error("Digit left BCD range.");

    chk_stopped_count_kept: assert property (
        !run_reg && !clear_wr |=> cnt_reg == $past(cnt_reg))
        else $error("Count moved while stopped.");

    chk_run_on_tick: assert property (
        run_reg != $past(run_reg) |-> $past(tick_reg))
        else $error("Run state changed off the tick.");

    chk_clear_zero_count: assert property (
        clear_wr && !lap_press |=> cnt_reg == COUNT_ZERO && cap_reg == $past(cap_reg))
        else $error("Clear did not zero count or touched buffer.");

    chk_skip_drops_pulse: assert property (
        tick_reg && run_reg && skip_reg && !clear_wr |=> cnt_reg == $past(cnt_reg) && !skip_reg)
        else $error("Suppressed pulse advanced the count.");

    chk_ms_read_latch: assert property (
        free_ms_read |=> hold_reg && cap_reg == $past(cnt_reg))
        else $error("Millisecond read did not latch.");

    chk_tenths_release: assert property (
        plain_tenths_read |=> !hold_reg ##1 !renewed_reg)
        else $error("Tenths read did not release hold.");

    chk_lap_renew_hold: assert property (
        lap_press && hold_reg |=> renewed_reg && hold_reg)
        else $error("Lap during hold did not mark renewal.");

    chk_one_second_flag: assert property (
        sec_evt |=> sec_flag_reg && cnt_reg.tenths_digit == DIGIT_ZERO)
        else $error("Tenths rollover missed the one-second flag.");

    chk_key_toggle_run: assert property (
        tick_reg && run_press |=> run_reg != $past(run_reg) ##1 key_irq == 1'b0)
        else $error("Run key did not toggle.");

endmodule // bcd_stopwatch_timer

/* test/key_model.sv */
// Pushbutton model for the stopwatch bench: two keys, pressed reads high.
// Assumes the bench asks for presses with one-cycle requests on pclk.
module key_model (
    // Clock and requests
    input  wire logic       pclk,
    input  wire logic [1:0] press_req,
    // Key lines
    output logic      [1:0] key_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================
    // Key hold
    // A press stays down for five ticks; the pull-down then returns the line low.
    int down_0 = 0;
    int down_1 = 0;
    always @(posedge pclk)
    begin
        down_0 <= press_req[0] ? 100 : (down_0 > 0 ? down_0 - 1 : 0);
        down_1 <= press_req[1] ? 100 : (down_1 > 0 ? down_1 - 1 : 0);
    end
    // The caller spaces presses beyond the release debounce window.
    assign key_level = {down_1 > 0, down_0 > 0};
endmodule // key_model

/* test/tb_bcd_stopwatch_timer.sv */
// Self-checking bench for the BCD stopwatch timer over APB and keys.
// Assumes a shortened tick of 20 pclk cycles and the key model on both ports.
module tb_bcd_stopwatch_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import stopwatch_pkg::*;
    localparam int TK = 20;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, v, s;
    logic        pready, pslverr, err, run_state, key_irq;
    logic [1:0]  press_req = 2'b00, keys;
    int          bad_count = 0, total_checks = 0, irq_count = 0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) if (key_irq === 1'b1) irq_count++;
    bcd_stopwatch_timer #(.TICK_CYCLES_P(TK)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_port_zero(keys[0]),
        .key_port_one(keys[1]), .run_state(run_state), .key_irq(key_irq));
    key_model key_i (.pclk(pclk), .press_req(press_req), .key_level(keys));
    // ==================================================
    // Tasks
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1 && ++n < 100);
        if (n >= 100) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Digits are read low to high so the snapshot stays consistent.
    task automatic read3();
        apb(1'b0, IDX_MS, 0);
        v = rd[3:0];
        apb(1'b0, IDX_HUND, 0);
        v = v + 10 * rd[3:0];
        apb(1'b0, IDX_TENTHS, 0);
        v = v + 100 * rd[3:0];
    endtask
    task automatic press(input int k);
        press_req[k] <= 1'b1;
        @(posedge pclk);
        press_req[k] <= 1'b0;
        repeat (1400) @(posedge pclk);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end
    // ==================================================
    // Tests
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, IDX_CTRL, 0);
        chk("ctrl", 0, rd);
        apb(1'b0, 16'h0000, 0);
        chk("unmapped", 1, err);
        apb(1'b1, IDX_CTRL, 1);
        repeat (TK + 4) @(posedge pclk);
        chk("run", 1, run_state);
        repeat (200 * TK) @(posedge pclk);
        apb(1'b1, IDX_CTRL, 0);
        repeat (TK + 4) @(posedge pclk);
        read3();
        chk("count", 1, v >= 194 && v <= 200);
        apb(1'b0, IDX_STATUS, 0);
        chk("released", 0, rd[ST_HOLD_BIT]);
        s = v;
        repeat (20 * TK) @(posedge pclk);
        read3();
        chk("retained", s, v);
        apb(1'b1, IDX_CTRL, 2);
        read3();
        chk("cleared", 0, v);
        apb(1'b0, IDX_MS, 0);
        apb(1'b0, IDX_STATUS, 0);
        chk("hold", 1, rd[ST_HOLD_BIT]);
        apb(1'b0, IDX_TENTHS, 0);
        apb(1'b1, IDX_CTRL, 4);
        press(0);
        chk("key run", 1, run_state);
        chk("key irq", 1, irq_count);
        apb(1'b1, IDX_CTRL, 4);
        repeat (TK + 4) @(posedge pclk);
        apb(1'b0, IDX_CTRL, 0);
        chk("run ro", 5, rd[3:0]);
        press(1);
        press(1);
        apb(1'b0, IDX_TENTHS, 0);
        apb(1'b0, IDX_STATUS, 0);
        chk("renew", 3, rd[1:0]);
        apb(1'b0, IDX_TENTHS, 0);
        apb(1'b1, IDX_CTRL, 12);
        press(1);
        chk("swap run", 0, run_state);
        chk("irq total", 4, irq_count);
        // Leave direct mode with a clear, then run past one full second.
        apb(1'b1, IDX_CTRL, 2);
        apb(1'b1, IDX_CTRL, 1);
        repeat (1040 * TK) @(posedge pclk);
        apb(1'b0, IDX_STATUS, 0);
        chk("flags", 32'h0000001C, rd);
        apb(1'b1, IDX_STATUS, 32'h0000001C);
        apb(1'b0, IDX_STATUS, 0);
        chk("flags cleared", 0, rd);
        apb(1'b1, IDX_CTRL, 3);
        repeat (5 * TK) @(posedge pclk);
        read3();
        chk("run clear", 1, v >= 3 && v <= 6);
        press_req[0] <= 1'b1;
        @(posedge pclk);
        press_req[0] <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b0, IDX_STATUS, 0);
        chk("key level", 1, rd[ST_KEY0_BIT]);
        end_of_test();
    end
endmodule // tb_bcd_stopwatch_timer
